/* logic/rst_clk_pkg.sv */
// package: constants, register map and carrier types for the reset and clock sequencer
package rst_clk_pkg;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_MHZ      = 100;                   // oscillator clock rate
    localparam int POR_TIME_US  = 600;                   // self-driven reset pin pulse, typical
    localparam int POR_CYCLES   = POR_TIME_US * CLK_MHZ; // 60000 oscillator cycles
    localparam int WARM_MIN_CYC = 32;                    // least external low time accepted
    localparam int WDOG_CYC     = 512;                   // watchdog reset pulse length
    localparam int EXDLY_CYC    = 32;                    // bus valid delay after pin high
    localparam int LOCK_CYC     = 2000;                  // lock interval in bypass
    // ----------------------------------------
    // register map (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] ADR_CTRL   = 8'h00; // main_pll_control_reg
    localparam logic [7:0] ADR_MULT   = 8'h04; // main_pll_multiplier_reg
    localparam logic [7:0] ADR_SYSDIV = 8'h08; // system_divider_select
    localparam logic [7:0] ADR_CLKOUT = 8'h0c; // clock_output_control_reg
    localparam logic [7:0] ADR_STATUS = 8'h10; // read-only state
    // field positions
    localparam int CTRL_BYP_B   = 0;
    localparam int MULT_INT_LSB = 0;  // pll_integer_multiplier [6:0]
    localparam int MULT_FRC_LSB = 8;  // pll_fraction_multiplier [9:8]
    localparam int CLKO_DIV_LSB = 0;  // clock_output_divider_field [1:0]
    localparam int CLKO_EN_B    = 4;
    localparam int STAT_LOCK_B  = 0;
    localparam int STAT_BYP_B   = 1;
    localparam int STAT_BUS_B   = 2;
    localparam int STAT_BOOT_LSB = 8;
    // reset values
    localparam logic       BYPASS_RST = 1'b1;
    localparam logic [6:0] IMULT_RST  = 7'h01;
    localparam logic [1:0] FMULT_RST  = 2'h0;
    localparam logic [1:0] SYSDIV_RST = 2'h3; // divide by eight
    localparam logic [1:0] SYSDIV_ONE = 2'h0; // divide by one
    localparam logic [1:0] CLKO_RST   = 2'h0; // divide by four
    localparam logic [1:0] CLKO_STOP  = 2'h3;
    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef enum logic [2:0] {ST_POR, ST_WDOG, ST_HOLD, ST_EXDLY, ST_RUN} seq_e;
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [7:0]  adr;
        logic [31:0] dat;
    } wb_req_s;
    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } wb_rsp_s;
endpackage : rst_clk_pkg

/* logic/sync2.sv */
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module sync2 #(
    parameter int W = 1
) (
    input  wire logic         clk_sys,
    input  wire logic         nrst,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] metaQ; // first stage, read only by the second

    // pins idle high after reset so the reset pin does not look asserted
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            metaQ <= '1;
            dout  <= '1;
        end else begin
            metaQ <= din;
            dout  <= metaQ;
        end
    end
endmodule : sync2

/* logic/clk_en_div.sv */
// enable divider: one tick every ratio input enables
`timescale 1ns/1ps
module clk_en_div #(
    parameter int W = 4
) (
    input  wire logic         clk_sys,
    input  wire logic         nrst,
    input  wire logic         en,
    input  wire logic [W-1:0] ratio,
    output logic              tick
);
    logic [W-1:0] cntQ; // enables seen since last tick

    initial begin
        if (W < 2) $error("clk_en_div: W too small");
    end

    // ratio of zero behaves as one
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            cntQ <= '0;
            tick <= 1'b0;
        end else begin
            tick <= 1'b0;
            if (en) begin
                if (cntQ + W'(1) >= ratio) begin
                    cntQ <= '0;
                    tick <= 1'b1;
                end else begin
                    cntQ <= cntQ + W'(1);
                end
            end
        end
    end
endmodule : clk_en_div

/* logic/reset_pll_seq.sv */
// reset sequencer, pll bypass control and clock output divider with wishbone registers
// Operation
// - power-up system clock is oscillator over eight
// - output divider resets to zero, meaning four
// - firmware selects divide-by-one, output oscillator/4
// - clock output pin off until software enables
// - boot pins latched at release for firmware
// - power-on drives reset pin low 600us
// - watchdog reset pulse lasts 512 cycles
// - bus valid 32 cycles after pin high
// - power-on reset generated internally, pin optional
// - bypass makes system clock equal oscillator over the divider
// - multiplier register has integer and fraction
// - leaving bypass switches to multiplied clock
`timescale 1ns/1ps
module reset_pll_seq
    import rst_clk_pkg::*;
#(
    parameter int PorCycles = POR_CYCLES, // shorten for simulation
    parameter int BootW     = 4
) (
    input  wire logic             clk_sys,
    input  wire logic             nrst,
    input  wire wb_req_s          wbReq,
    output wb_rsp_s               wbRsp,
    input  wire logic             rstPinIn,
    output logic                  rstPinOut,
    output logic                  rstPinOe,
    input  wire logic             wdogTrip,
    input  wire logic [BootW-1:0] bootPins,
    output logic [BootW-1:0]      bootMode,
    output logic                  sysRstN,
    output logic                  busValid,
    output logic                  extClkOut,
    output logic                  extClkOe,
    output logic [6:0]            pllIntActive,
    output logic [1:0]            pllFrcActive
);
    // ----------------------------------------
    // elaboration checks
    // ----------------------------------------
    initial begin
        if (PorCycles < 1 || PorCycles > 65535) $error("reset_pll_seq: PorCycles out of range");
        if (BootW < 1 || BootW > 8) $error("reset_pll_seq: BootW out of range");
    end

    // ----------------------------------------
    // declarations
    // ----------------------------------------
    seq_e             stateQ;        // sequencer state
    logic [15:0]      cntQ;          // phase counter
    logic [5:0]       lowCntQ;       // external low filter
    logic             rstPinSync;    // reset pin after synchroniser
    logic [BootW-1:0] bootSync;      // boot pins after synchroniser
    logic             bypassQ;       // software bypass request
    logic             bypassActQ;    // bypass as applied to the clock
    logic [6:0]       imultQ;        // integer multiplier field
    logic [1:0]       fmultQ;        // fraction multiplier field
    logic [1:0]       sysDivQ;       // system divider select code
    logic [1:0]       clkoDivQ;      // clock output divider field
    logic             clkoEnQ;       // clock output pin enable
    logic [10:0]      lockCntQ;      // cycles spent in bypass since multiplier write
    logic             pllTick;       // system clock enable
    logic             extTick;       // clock output enable
    logic             inReset;       // block held in reset
    logic             regRst;        // register reset
    logic             wbHit;         // new access this cycle
    logic             wrCtrl;        // write strobe, control register
    logic             wrMult;        // write strobe, multiplier register
    logic             lockDone;      // lock interval elapsed

    assign inReset = (stateQ == ST_POR) || (stateQ == ST_WDOG) || (stateQ == ST_HOLD);
    assign regRst  = !nrst || inReset;
    assign wbHit   = wbReq.cyc && wbReq.stb && !wbRsp.ack;
    assign wrCtrl  = wbHit && wbReq.we && wbReq.sel[0] && (wbReq.adr == ADR_CTRL);
    assign wrMult  = wbHit && wbReq.we && (wbReq.adr == ADR_MULT);
    assign lockDone = (lockCntQ == 11'(LOCK_CYC));

    // divide code to enable ratio: 0..3 gives 1,2,4,8
    function automatic logic [3:0] sysRatio(input logic [1:0] code);
        sysRatio = 4'h1 << code;
    endfunction : sysRatio

    // output divider field to ratio: 0 -> 4, 1 -> 2, 2 -> 1
    function automatic logic [3:0] clkoRatio(input logic [1:0] code);
        clkoRatio = (code == CLKO_STOP) ? 4'h4 : (4'h4 >> code);
    endfunction : clkoRatio

    // half pin period in oscillator cycles: the pin toggles once per tick, so the product is halved;
    // a product of one cannot be served and gives a period of two
    function automatic logic [4:0] clkoHalf(input logic [1:0] sysCode, input logic [1:0] outCode);
        logic [5:0] full;
        full = 6'(sysRatio(sysCode)) * 6'(clkoRatio(outCode));
        clkoHalf = full[5:1];
    endfunction : clkoHalf

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    sync2 #(.W(1)) uRstSync (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .din     (rstPinIn),
        .dout    (rstPinSync)
    );

    sync2 #(.W(BootW)) uBootSync (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .din     (bootPins),
        .dout    (bootSync)
    );

    // ----------------------------------------
    // reset sequencer
    // ----------------------------------------
    // nrst is the on-chip power-on event; the board pin is not needed for it
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            stateQ <= ST_POR;
            cntQ   <= '0;
        end else begin
            unique case (stateQ)
                ST_POR: begin
                    if (cntQ == 16'(PorCycles - 1)) begin
                        stateQ <= ST_HOLD;
                        cntQ   <= '0;
                    end else begin
                        cntQ <= cntQ + 16'h0001;
                    end
                end
                ST_WDOG: begin
                    if (cntQ == 16'(WDOG_CYC - 1)) begin
                        stateQ <= ST_HOLD;
                        cntQ   <= '0;
                    end else begin
                        cntQ <= cntQ + 16'h0001;
                    end
                end
                // wait for the board to let the pin rise
                ST_HOLD: begin
                    if (rstPinSync) begin
                        stateQ <= ST_EXDLY;
                        cntQ   <= '0;
                    end
                end
                ST_EXDLY: begin
                    if (wdogTrip) begin
                        stateQ <= ST_WDOG;
                        cntQ   <= '0;
                    end else if (lowCntQ == 6'(WARM_MIN_CYC - 1)) begin
                        stateQ <= ST_HOLD;
                    end else if (cntQ == 16'(EXDLY_CYC - 1)) begin
                        stateQ <= ST_RUN;
                        cntQ   <= '0;
                    end else begin
                        cntQ <= cntQ + 16'h0001;
                    end
                end
                ST_RUN: begin
                    if (wdogTrip) begin
                        stateQ <= ST_WDOG;
                        cntQ   <= '0;
                    end else if (lowCntQ == 6'(WARM_MIN_CYC - 1)) begin
                        stateQ <= ST_HOLD;
                    end
                end
                default: begin
                    stateQ <= ST_POR;
                    cntQ   <= '0;
                end
            endcase
        end
    end

    // warm reset filter: shorter low glitches are ignored
    always_ff @(posedge clk_sys) begin
        if (!nrst || inReset || rstPinSync) begin
            lowCntQ <= '0;
        end else if (lowCntQ != 6'(WARM_MIN_CYC - 1)) begin
            lowCntQ <= lowCntQ + 6'h01;
        end
    end

    // pin drive and reset outputs, all registered
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            rstPinOut <= 1'b0;
            rstPinOe  <= 1'b1;
            sysRstN   <= 1'b0;
            busValid  <= 1'b0;
        end else begin
            rstPinOut <= 1'b0;
            rstPinOe  <= (stateQ == ST_POR) || (stateQ == ST_WDOG);
            sysRstN   <= !inReset;
            busValid  <= (stateQ == ST_RUN);
        end
    end

    // boot strap capture when the pin release is seen
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            bootMode <= '0;
        end else if (stateQ == ST_HOLD && rstPinSync) begin
            bootMode <= bootSync;
        end
    end

    // ----------------------------------------
    // software registers
    // ----------------------------------------
    // pll control and multiplier; a warm or watchdog reset restores power-up values
    always_ff @(posedge clk_sys) begin
        if (regRst) begin
            bypassQ <= BYPASS_RST;
            imultQ  <= IMULT_RST;
            fmultQ  <= FMULT_RST;
        end else begin
            if (wrCtrl) begin
                bypassQ <= wbReq.dat[CTRL_BYP_B];
            end
            // multiplier only changes while bypassed, else the clock would jump
            if (wrMult && bypassQ && bypassActQ) begin
                if (wbReq.sel[0]) imultQ <= wbReq.dat[MULT_INT_LSB +: 7];
                if (wbReq.sel[1]) fmultQ <= wbReq.dat[MULT_FRC_LSB +: 2];
            end
        end
    end

    // divider select and clock output control
    always_ff @(posedge clk_sys) begin
        if (regRst) begin
            sysDivQ  <= SYSDIV_RST;
            clkoDivQ <= CLKO_RST;
            clkoEnQ  <= 1'b0;
        end else if (wbHit && wbReq.we && wbReq.sel[0]) begin
            if (wbReq.adr == ADR_SYSDIV) sysDivQ <= wbReq.dat[1:0];
            if (wbReq.adr == ADR_CLKOUT) begin
                clkoDivQ <= wbReq.dat[CLKO_DIV_LSB +: 2];
                clkoEnQ  <= wbReq.dat[CLKO_EN_B];
            end
        end
    end

    // lock timer: restarts on every multiplier write, runs only in bypass
    always_ff @(posedge clk_sys) begin
        if (regRst || wrMult || !bypassActQ) begin
            lockCntQ <= '0;
        end else if (!lockDone) begin
            lockCntQ <= lockCntQ + 11'h001;
        end
    end

    // wishbone answer: one cycle after the request, zero for unmapped reads
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            wbRsp <= '0;
        end else begin
            wbRsp.ack <= wbHit;
            wbRsp.dat <= '0;
            if (wbHit && !wbReq.we) begin
                unique case (wbReq.adr)
                    ADR_CTRL:   wbRsp.dat[CTRL_BYP_B] <= bypassQ;
                    ADR_MULT:   wbRsp.dat <= {22'h0, fmultQ, 1'b0, imultQ};
                    ADR_SYSDIV: wbRsp.dat[1:0] <= sysDivQ;
                    ADR_CLKOUT: wbRsp.dat <= {27'h0, clkoEnQ, 2'h0, clkoDivQ};
                    ADR_STATUS: begin
                        wbRsp.dat[STAT_LOCK_B] <= lockDone;
                        wbRsp.dat[STAT_BYP_B]  <= bypassActQ;
                        wbRsp.dat[STAT_BUS_B]  <= busValid;
                        wbRsp.dat[STAT_BOOT_LSB +: BootW] <= bootMode;
                    end
                    default: wbRsp.dat <= '0;
                endcase
            end
        end
    end

    // ----------------------------------------
    // clock enables
    // ----------------------------------------
    clk_en_div #(.W(4)) uSysDiv (
        .clk_sys (clk_sys),
        .nrst    (nrst && !regRst),
        .en      (1'b1),
        .ratio   (sysRatio(sysDivQ)),
        .tick    (pllTick)
    );

    clk_en_div #(.W(5)) uOutDiv (
        .clk_sys (clk_sys),
        .nrst    (nrst && !regRst),
        .en      (clkoDivQ != CLKO_STOP),
        .ratio   (clkoHalf(sysDivQ, clkoDivQ)),
        .tick    (extTick)
    );

    // bypass takes effect only on a system tick so no short clock phase appears
    always_ff @(posedge clk_sys) begin
        if (regRst) begin
            bypassActQ   <= BYPASS_RST;
            pllIntActive <= 7'h01;
            pllFrcActive <= 2'h0;
        end else if (pllTick) begin
            bypassActQ <= bypassQ;
            if (bypassQ) begin
                pllIntActive <= 7'h01;
                pllFrcActive <= 2'h0;
            end else begin
                pllIntActive <= imultQ;
                pllFrcActive <= fmultQ;
            end
        end
    end

    // output pin toggles on each output tick, driven only when enabled
    always_ff @(posedge clk_sys) begin
        if (regRst) begin
            extClkOut <= 1'b0;
            extClkOe  <= 1'b0;
        end else begin
            extClkOe <= clkoEnQ;
            if (extTick) extClkOut <= !extClkOut;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    sequence sDivEight;
        pllTick ##1 !pllTick [*7] ##1 pllTick;
    endsequence

    chk_por_divide: assert property (disable iff (!nrst || regRst || sysDivQ != SYSDIV_RST)
        pllTick |-> sDivEight)
        else $error("system clock not oscillator over eight");
    chk_out_div_rst: assert property ($fell(sysRstN) |=> clkoDivQ == CLKO_RST)
        else $error("output divider not zero after reset");
    chk_div_one: assert property (pllTick && sysDivQ == SYSDIV_ONE && $stable(sysDivQ) && !regRst
        |=> pllTick || regRst)
        else $error("divide by one not every cycle");
    chk_pin_off: assert property (!clkoEnQ |=> !extClkOe)
        else $error("clock output driven while disabled");
    chk_boot_latch: assert property (stateQ == ST_HOLD && rstPinSync |=> bootMode == $past(bootSync))
        else $error("boot mode not captured at release");
    chk_por_len: assert property (stateQ == ST_POR ##1 stateQ != ST_POR |-> $past(cntQ) == 16'(PorCycles - 1))
        else $error("power-on pulse length wrong");
    chk_wdog_len: assert property (stateQ == ST_WDOG ##1 stateQ != ST_WDOG |-> $past(cntQ) == 16'(WDOG_CYC - 1))
        else $error("watchdog pulse length wrong");
    chk_bus_valid: assert property ($rose(busValid) |-> $past(cntQ, 2) == 16'(EXDLY_CYC - 1))
        else $error("bus valid delay wrong");
    chk_bypass_one: assert property (bypassActQ |-> pllIntActive == 7'h01 && pllFrcActive == 2'h0)
        else $error("bypass not at oscillator rate");
    chk_clean_switch: assert property ($changed(bypassActQ) && !$past(regRst) |-> $past(pllTick))
        else $error("clock switched off a tick boundary");
endmodule : reset_pll_seq

/* tb/board_model.sv */
// board model: reset pin with pull-up and boot strap drivers
`timescale 1ns/1ps
module board_model #(
    parameter int HoldCyc = 14000 // strap hold after pin release
) (
    input  wire logic       clk_sys,
    input  wire logic       rstPinOe,
    input  wire logic       rstPinOut,
    output logic            rstPinIn,
    output logic [3:0]      bootPins
);
    logic       pullLow = 1'b0; // board pulls pin low
    int         holdCnt = 0;    // strap hold cycles left
    logic [3:0] bootVal = 4'ha; // strap level
    logic       pinPrev = 1'b0; // pin level last cycle
    // open drain wire, pull-up wins when nobody drives
    assign rstPinIn = ((rstPinOe && !rstPinOut) || pullLow) ? 1'b0 : 1'b1;
    assign bootPins = bootVal;
    // restart the strap hold at every pin release
    always @(posedge clk_sys) begin
        pinPrev <= rstPinIn;
        if (rstPinIn && !pinPrev) holdCnt <= HoldCyc;
        else if (holdCnt > 0) holdCnt <= holdCnt - 1;
    end
    // straps move only once the hold ran out
    task automatic set_boot(input logic [3:0] v);
        while (holdCnt > 0) @(posedge clk_sys);
        bootVal <= v;
    endtask : set_boot
    // warm reset: pin held low for n cycles
    task automatic warm(input int n);
        @(posedge clk_sys);
        pullLow <= 1'b1;
        repeat (n) @(posedge clk_sys);
        pullLow <= 1'b0;
    endtask : warm
endmodule : board_model

/* tb/reset_pll_seq_bench.sv */
// self-checking bench for the reset and pll sequencer
`timescale 1ns/1ps
module reset_pll_seq_bench
    import rst_clk_pkg::*;
;
    localparam int PorSim = 40; // shortened power-on pulse
    logic        clk_sys  = 1'b0;
    logic        nrst     = 1'b0;
    wb_req_s     wbReq    = '0;
    wb_rsp_s     wbRsp;
    logic        rstPinIn, rstPinOut, rstPinOe, sysRstN, busValid, extClkOut, extClkOe;
    logic        wdogTrip = 1'b0;
    logic [3:0]  bootPins, bootMode;
    logic [6:0]  pllIntActive;
    logic [1:0]  pllFrcActive;
    logic [31:0] expReg [int]; // register model by address
    logic [31:0] q;
    int          err_total = 0, samples_checked = 0, seed, n, p, sd, dv;
    always #5 clk_sys = ~clk_sys;
    reset_pll_seq #(.PorCycles(PorSim), .BootW(4)) u_reset_pll_seq (
        .clk_sys(clk_sys), .nrst(nrst), .wbReq(wbReq), .wbRsp(wbRsp),
        .rstPinIn(rstPinIn), .rstPinOut(rstPinOut), .rstPinOe(rstPinOe),
        .wdogTrip(wdogTrip), .bootPins(bootPins), .bootMode(bootMode),
        .sysRstN(sysRstN), .busValid(busValid), .extClkOut(extClkOut),
        .extClkOe(extClkOe), .pllIntActive(pllIntActive), .pllFrcActive(pllFrcActive));
    board_model u_board_model (.clk_sys(clk_sys), .rstPinOe(rstPinOe),
        .rstPinOut(rstPinOut), .rstPinIn(rstPinIn), .bootPins(bootPins));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    // model back at reset values, also after warm or watchdog reset
    task automatic reset_model();
        expReg[0] = 32'h1; expReg[4] = 32'h1; expReg[8] = 32'h3; expReg[12] = 32'h0;
    endtask : reset_model
    // one classic cycle, held until ack is sampled
    task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        wbReq <= '{cyc:1'b1, stb:1'b1, we:we, sel:4'hf, adr:a, dat:d};
        do @(posedge clk_sys); while (wbRsp.ack !== 1'b1); // ends once ack is seen; no timeout of its own, only the hang guard stops a missing ack
        q = wbRsp.dat;
        wbReq <= '0;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
        case (a)
            8'h00: expReg[0] = d & 32'h1;
            8'h04: if (expReg[0][0]) expReg[4] = d & 32'h37f; // multiplier only in bypass
            8'h08: expReg[8] = d & 32'h3;
            8'h0c: expReg[12] = d & 32'h13;
            default: ;
        endcase
    endtask : wr
    task automatic rd(input logic [7:0] a);
        bus(1'b0, a, 32'h0);
        check(q, expReg.exists(a) ? expReg[a] : 32'h0);
    endtask : rd
    // cycles until the clock output pin rises
    task automatic wait_rise(output int c);
        logic prv;
        c = 0;
        do begin prv = extClkOut; @(posedge clk_sys); c++; end
        while (!(extClkOut && !prv) && c < 400);
    endtask : wait_rise
    task automatic measure(output int c);
        wait_rise(c); wait_rise(c); wait_rise(c);
    endtask : measure
    // length of the device driving the pin low
    task automatic oe_len(output int c);
        int w;
        c = 0; w = 0;
        while (rstPinOe !== 1'b1 && w < 20) begin @(posedge clk_sys); w++; end
        while (rstPinOe === 1'b1 && c < 9000) begin @(posedge clk_sys); c++; end
    endtask : oe_len
    task automatic bus_valid_delay(output int c);
        c = 0;
        while (busValid !== 1'b1 && c < 300) begin @(posedge clk_sys); c++; end
    endtask : bus_valid_delay
    task automatic tally_and_finish();
        $display("mismatches %0d of %0d compares", err_total, samples_checked);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : tally_and_finish
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        seed = 26;
        repeat (16) @(posedge clk_sys);
        nrst <= 1'b1;
        oe_len(n);
        check(32'(n >= PorSim && n <= PorSim + 2), 1);
        check(rstPinOut, 1'b0);
        bus_valid_delay(n);
        check(32'(n >= EXDLY_CYC && n <= EXDLY_CYC + 4), 1);
        reset_model();
        foreach (expReg[a]) rd(8'(a));
        rd(8'h14); // unmapped place reads zero
        check(bootMode, 4'ha);
        check(extClkOe, 1'b0);
        wr(8'h0c, 32'h10);
        @(posedge clk_sys);
        check(extClkOe, 1'b1);
        measure(p); check(p, 32);
        wr(8'h08, 32'h0);
        measure(p); check(p, 4);
        repeat (4) begin
            sd = $random(seed) & 3;
            dv = ($random(seed) & 32'hff) % 3;
            if (((1 << sd) * (4 >> dv)) < 2) dv = 0; // pin cannot toggle faster than the clock
            wr(8'h08, sd); wr(8'h0c, 32'h10 | dv);
            measure(p); check(p, (1 << sd) * (4 >> dv));
        end
        wr(8'h04, 32'h205); rd(8'h04);
        check({pllFrcActive, pllIntActive}, 9'h001);
        repeat (LOCK_CYC + 4) @(posedge clk_sys);
        expReg[16] = 32'h7 | (32'ha << 8);
        rd(8'h10);
        wr(8'h00, 32'h0);
        n = 0;
        while (pllIntActive !== 7'h05 && n < 100) begin @(posedge clk_sys); n++; end
        check({pllFrcActive, pllIntActive}, 9'h105);
        wr(8'h04, 32'h107); rd(8'h04);
        u_board_model.set_boot(4'h5);
        u_board_model.warm(20);
        n = 1;
        repeat (100) begin @(posedge clk_sys); if (sysRstN !== 1'b1) n = 0; end
        check(n, 1);
        u_board_model.warm(WARM_MIN_CYC + 8);
        n = 0;
        while (sysRstN !== 1'b0 && n < 60) begin @(posedge clk_sys); n++; end
        check(sysRstN, 1'b0);
        bus_valid_delay(n);
        reset_model(); expReg.delete(16);
        rd(8'h00); rd(8'h08);
        check(bootMode, 4'h5);
        wr(8'h0c, 32'h11);
        @(posedge clk_sys); wdogTrip <= 1'b1;
        @(posedge clk_sys); wdogTrip <= 1'b0;
        oe_len(n);
        check(32'(n >= WDOG_CYC && n <= WDOG_CYC + 2), 1);
        bus_valid_delay(n);
        reset_model();
        rd(8'h0c); rd(8'h04);
        tally_and_finish();
    end
    // hang guard, well past the longest expected run
    initial begin
        repeat (60000) @(posedge clk_sys);
        err_total++;
        tally_and_finish();
    end
endmodule : reset_pll_seq_bench
